// ---- verilog/edpc_pkg.sv ----
// Constants for the energy detect power control block
// Assumes a 40 MHz reference clock and a register port at word offset 0x1D
package edpc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [4:0]  REG_ADDR        = 5'h1D;
	localparam int          BIT_ENABLE      = 15;
	localparam int          BIT_AUTO_UP     = 14;
	localparam int          BIT_AUTO_DOWN   = 13;
	localparam int          BIT_MANUAL      = 12;
	localparam int          BIT_BURST_DIS   = 11;
	localparam int          BIT_PWR_STATE   = 10;
	localparam int          BIT_ERR_MET     = 9;
	localparam int          BIT_DATA_MET    = 8;
	localparam int          ERR_THR_LSB     = 4;
	localparam int          DATA_THR_LSB    = 0;
	localparam logic [3:0]  THR_RESET       = 4'h1;
	localparam logic        ENABLE_RESET    = 1'h0;
	localparam logic        AUTO_RESET      = 1'h1;
	// ----------------------------------------------------------------
	// Pulse burst and idle timing
	// ----------------------------------------------------------------
	localparam logic [2:0]  BURST_LEN       = 3'h4;
	localparam logic [2:0]  SINGLE_LEN      = 3'h1;
	localparam int          CLOCK_HZ        = 40000000;
	localparam int          IDLE_TIME_S     = 2;
	localparam int          PRESCALE_CYCLES = 40000;
	localparam int          IDLE_TICKS      =
		(IDLE_TIME_S * CLOCK_HZ) / PRESCALE_CYCLES;
	localparam logic [15:0] PRESCALE_LAST   = 16'(PRESCALE_CYCLES - 1);
	localparam logic [15:0] IDLE_TICKS_LAST = 16'(IDLE_TICKS - 1);
endpackage

// ---- verilog/edpc_top.sv ----
// Energy detect power control with its control/status register
// Assumes line event inputs are asynchronous pins, register port is local
`timescale 1ns/1ps

//Contract
// (R1) Energy detect mode acts only while enable bit set; enable resets clear.
// (R2) Auto power-up starts when counted data events reach the data threshold.
// (R3) Auto power-down starts once no energy is detected on the line.
// (R4) Writing manual bit toggles power state regardless; bit self-clears. Here the toggle acts only while enable bit set.
// (R5) Transmit driver power-up sends four pulses, or one when burst disabled.
// (R6) Read-only power state bit is one while powered up.
// (R7) Error threshold only sets sticky informational flag; read clears it.
// (R8) Data threshold met sets sticky flag; read clears it.
// (R9) Four-bit error threshold field, writable, defaults to one.
// (R10) Four-bit data threshold field, writable, defaults to one.
// (R11) Event counters clear after about two seconds without data events.
// (R12) Software may set manual bit after clearing the interrupt.
// (R13) Idle timeout from prescaled counter, restarted on each data event.
module edpc_top (
	// Clock and reset
	input  wire logic        CLOCK_IN,
	input  wire logic        RST_IN,
	// Register port
	input  wire logic [4:0]  REG_ADDR_IN,
	input  wire logic        REG_WRITE_IN,
	input  wire logic        REG_READ_IN,
	input  wire logic [15:0] REG_WDATA_IN,
	output logic      [15:0] REG_RDATA_OUT,
	// Line side events
	input  wire logic        ENERGY_PRESENT_IN,
	input  wire logic        DATA_EVENT_IN,
	input  wire logic        ERROR_EVENT_IN,
	input  wire logic        TRANSMIT_DRIVER_UP_IN,
	// Power control
	output logic             POWER_UP_START_OUT,
	output logic             POWER_DOWN_START_OUT,
	output logic             POWER_STATE_OUT,
	output logic             PULSE_OUT
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       data_prev;
	logic       err_prev;
	logic       drv_prev;

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {TRANSMIT_DRIVER_UP_IN, ERROR_EVENT_IN,
				DATA_EVENT_IN, ENERGY_PRESENT_IN};
			sync_b <= sync_a;
		end
	end

	// Previous levels for edge detection, idle low like the pins
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			data_prev <= 1'h0;
		else
			data_prev <= sync_b[1];
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			err_prev <= 1'h0;
		else
			err_prev <= sync_b[2];
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			drv_prev <= 1'h0;
		else
			drv_prev <= sync_b[3];
	end

	logic energy;
	logic data_ev;
	logic err_ev;
	logic drv_up;
	assign energy  = sync_b[0];
	assign data_ev = sync_b[1] & ~data_prev;
	assign err_ev  = sync_b[2] & ~err_prev;
	assign drv_up  = sync_b[3] & ~drv_prev;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic       ena;
	logic       auto_up;
	logic       auto_down;
	logic       manual;
	logic       burst_dis;
	logic [3:0] err_thr;
	logic [3:0] data_thr;
	logic       sel;
	logic       wr;
	logic       rd;
	assign sel = REG_ADDR_IN == edpc_pkg::REG_ADDR;
	assign wr  = sel & REG_WRITE_IN;
	assign rd  = sel & REG_READ_IN;

	// Mode bits
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			ena       <= edpc_pkg::ENABLE_RESET; // [R1]
			auto_up   <= edpc_pkg::AUTO_RESET;
			auto_down <= edpc_pkg::AUTO_RESET;
			burst_dis <= 1'h0;
		end else if (wr) begin
			ena       <= REG_WDATA_IN[edpc_pkg::BIT_ENABLE];
			auto_up   <= REG_WDATA_IN[edpc_pkg::BIT_AUTO_UP];
			auto_down <= REG_WDATA_IN[edpc_pkg::BIT_AUTO_DOWN];
			burst_dis <= REG_WDATA_IN[edpc_pkg::BIT_BURST_DIS];
		end
	end

	// Threshold fields
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			err_thr  <= edpc_pkg::THR_RESET; // [R9]
			data_thr <= edpc_pkg::THR_RESET; // [R10]
		end else if (wr) begin
			err_thr  <= REG_WDATA_IN[edpc_pkg::ERR_THR_LSB +: 4]; // [R9]
			data_thr <= REG_WDATA_IN[edpc_pkg::DATA_THR_LSB +: 4]; // [R10]
		end
	end

	// Manual toggle request, held for one cycle then cleared whether or not acted on
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			manual <= 1'h0;
		else if (wr && REG_WDATA_IN[edpc_pkg::BIT_MANUAL])
			manual <= 1'h1;
		else
			manual <= 1'h0; // [R4]
	end

	// ----------------------------------------------------------------
	// Idle timer
	// ----------------------------------------------------------------
	logic [15:0] prescale;
	logic [15:0] ticks;
	logic        idle_expire;
	assign idle_expire = (ticks == edpc_pkg::IDLE_TICKS_LAST)
		&& (prescale == edpc_pkg::PRESCALE_LAST);

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN || data_ev || idle_expire) begin
			prescale <= 16'h0; // [R13]
			ticks    <= 16'h0;
		end else if (prescale == edpc_pkg::PRESCALE_LAST) begin
			prescale <= 16'h0;
			ticks    <= ticks + 16'h1;
		end else begin
			prescale <= prescale + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Event counters and sticky flags
	// ----------------------------------------------------------------
	logic [3:0] data_cnt;
	logic [3:0] err_cnt;
	logic [4:0] data_sum;
	logic [4:0] err_sum;
	logic       data_met;
	logic       err_met;
	logic       data_hit;
	logic       err_hit;
	// One bit wider so a saturated count still meets its threshold
	assign data_sum = {1'h0, data_cnt} + 5'h1;
	assign err_sum  = {1'h0, err_cnt} + 5'h1;
	assign data_hit = ena && data_ev
		&& (data_sum >= {1'h0, data_thr});
	assign err_hit  = ena && err_ev
		&& (err_sum >= {1'h0, err_thr});

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN || idle_expire || !ena)
			data_cnt <= 4'h0; // [R11]
		else if (data_ev && data_cnt != 4'hF)
			data_cnt <= data_cnt + 4'h1;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN || idle_expire || !ena)
			err_cnt <= 4'h0; // [R11]
		else if (err_ev && err_cnt != 4'hF)
			err_cnt <= err_cnt + 4'h1;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			data_met <= 1'h0;
		else
			data_met <= data_hit | (data_met & ~rd); // [R8]
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			err_met <= 1'h0;
		else
			err_met <= err_hit | (err_met & ~rd); // [R7]
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	typedef enum logic {PWR_DOWN, PWR_UP} edpc_pwr_type;
	edpc_pwr_type pwr;
	logic         go_up;
	logic         go_down;

	always_comb begin
		go_up   = 1'h0;
		go_down = 1'h0;
		if (ena) begin // [R1]
			unique case (pwr)
				PWR_DOWN: go_up = manual || (auto_up && data_hit); // [R2]
				PWR_UP:   go_down = manual || (auto_down && !energy); // [R3]
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			pwr <= PWR_DOWN;
		else if (go_up)
			pwr <= PWR_UP; // [R4]
		else if (go_down)
			pwr <= PWR_DOWN;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			POWER_UP_START_OUT <= 1'h0;
		else
			POWER_UP_START_OUT <= go_up; // [R2]
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			POWER_DOWN_START_OUT <= 1'h0;
		else
			POWER_DOWN_START_OUT <= go_down; // [R3]
	end
	assign POWER_STATE_OUT = pwr == PWR_UP; // [R6]

	// ----------------------------------------------------------------
	// Pulse burst on transmit driver power-up
	// ----------------------------------------------------------------
	logic [2:0] pulses_left;
	logic       gap;

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			pulses_left <= 3'h0;
			gap         <= 1'h0;
			PULSE_OUT   <= 1'h0;
		end else if (ena && drv_up) begin
			pulses_left <= burst_dis ? edpc_pkg::SINGLE_LEN
				: edpc_pkg::BURST_LEN; // [R5]
			gap         <= 1'h0;
			PULSE_OUT   <= 1'h0;
		end else if (pulses_left != 3'h0 && !gap) begin
			pulses_left <= pulses_left - 3'h1;
			gap         <= 1'h1;
			PULSE_OUT   <= 1'h1;
		end else begin
			gap       <= 1'h0;
			PULSE_OUT <= 1'h0;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [15:0] read_word;

	always_comb begin
		// Manual bit is not placed in the read word, so it reads zero
		read_word = 16'h0; // [R4]
		read_word[edpc_pkg::BIT_ENABLE]    = ena;
		read_word[edpc_pkg::BIT_AUTO_UP]   = auto_up;
		read_word[edpc_pkg::BIT_AUTO_DOWN] = auto_down;
		read_word[edpc_pkg::BIT_BURST_DIS] = burst_dis;
		read_word[edpc_pkg::BIT_PWR_STATE] = POWER_STATE_OUT; // [R6]
		read_word[edpc_pkg::BIT_ERR_MET]   = err_met;
		read_word[edpc_pkg::BIT_DATA_MET]  = data_met;
		read_word[edpc_pkg::ERR_THR_LSB +: 4]  = err_thr;
		read_word[edpc_pkg::DATA_THR_LSB +: 4] = data_thr;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			REG_RDATA_OUT <= 16'h0;
		else if (rd)
			REG_RDATA_OUT <= read_word;
		else
			REG_RDATA_OUT <= 16'h0;
	end
endmodule

// ---- test/edpc_monitor.sv ----
// Port checker for the energy detect power control block
// Assumes it is bound to edpc_top and sees only its ports
`timescale 1ns/1ps
module edpc_monitor (
	input wire logic        CLOCK_IN,
	input wire logic        RST_IN,
	input wire logic [4:0]  REG_ADDR_IN,
	input wire logic        REG_WRITE_IN,
	input wire logic        REG_READ_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic [15:0] REG_RDATA_OUT,
	input wire logic        TRANSMIT_DRIVER_UP_IN,
	input wire logic        POWER_UP_START_OUT,
	input wire logic        POWER_DOWN_START_OUT,
	input wire logic        POWER_STATE_OUT,
	input wire logic        PULSE_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	logic en;
	wire logic hit = REG_READ_IN && REG_ADDR_IN == edpc_pkg::REG_ADDR;
	// Shadow of the enable bit
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			en <= 1'h0;
		else if (REG_WRITE_IN && REG_ADDR_IN == edpc_pkg::REG_ADDR)
			en <= REG_WDATA_IN[edpc_pkg::BIT_ENABLE];
	end
	AST_RDATA_IDLE: assert property (!$past(hit) |->
		REG_RDATA_OUT == 16'h0)
		else $error("read data not zero when idle");
	AST_MANUAL_READ: assert property ($past(hit) |->
		!REG_RDATA_OUT[12])
		else $error("manual bit reads one");
	AST_STATE_READ: assert property ($past(hit) |->
		REG_RDATA_OUT[10] == $past(POWER_STATE_OUT))
		else $error("power state bit mismatch");
	AST_UP_EDGE: assert property (POWER_UP_START_OUT |->
		POWER_STATE_OUT && !$past(POWER_STATE_OUT))
		else $error("power up start without state rise");
	AST_DOWN_EDGE: assert property (POWER_DOWN_START_OUT |->
		!POWER_STATE_OUT && $past(POWER_STATE_OUT))
		else $error("power down start without state fall");
	AST_STATE_CAUSE: assert property ($changed(POWER_STATE_OUT) |->
		POWER_UP_START_OUT || POWER_DOWN_START_OUT)
		else $error("state changed without start pulse");
	AST_DISABLED: assert property (!$past(en) |->
		!POWER_UP_START_OUT)
		else $error("power up while disabled");
	AST_PULSE_GAP: assert property (PULSE_OUT |=> !PULSE_OUT)
		else $error("pulse longer than one cycle");
	AST_START_EXCL: assert property (!(POWER_UP_START_OUT
		&& POWER_DOWN_START_OUT))
		else $error("power up and down start together");
	AST_BURST: assert property (en && $rose(TRANSMIT_DRIVER_UP_IN)
		|-> ##[2:6] PULSE_OUT)
		else $error("no pulse after driver power up");
endmodule
bind edpc_top edpc_monitor edpc_monitor_i (.*);

// ---- test/edpc_line_model.sv ----
// Line side partner driving energy and event pins
// Assumes the block reference clock
`timescale 1ns/1ps
module edpc_line_model (
	input  wire logic clk_in,
	output logic      energy_out,
	output logic [2:0] ev_out
);
	initial begin
		energy_out = 1'h1;
		ev_out = 3'h0;
	end
	// One event: two cycles high, three low
	task automatic kick(input logic [2:0] m);
		@(posedge clk_in);
		ev_out <= m;
		repeat (2) @(posedge clk_in);
		ev_out <= 3'h0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic energy(input logic v);
		@(posedge clk_in);
		energy_out <= v;
	endtask
endmodule

// ---- test/tb.sv ----
// Testbench for the energy detect power control block
// Assumes edpc_top, the line model and the checker
`timescale 1ns/1ps
module tb;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [4:0]  addr = 5'h0;
	logic        wen = 1'h0;
	logic        ren = 1'h0;
	logic [15:0] wd = 16'h0;
	logic [15:0] rdata;
	logic        energy, state, pulse, up_start, down_start;
	logic [2:0]  ev;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          np = 0;
	int          nu = 0;
	int          nd = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk)
		if (pulse === 1'h1)
			np++;
	always @(posedge clk) begin
		if (up_start === 1'h1)
			nu++;
		if (down_start === 1'h1)
			nd++;
	end
	edpc_top edpc_top_i (.CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
		.REG_WRITE_IN(wen), .REG_READ_IN(ren), .REG_WDATA_IN(wd),
		.REG_RDATA_OUT(rdata), .ENERGY_PRESENT_IN(energy),
		.DATA_EVENT_IN(ev[0]), .ERROR_EVENT_IN(ev[1]),
		.TRANSMIT_DRIVER_UP_IN(ev[2]), .POWER_UP_START_OUT(up_start),
		.POWER_DOWN_START_OUT(down_start), .POWER_STATE_OUT(state),
		.PULSE_OUT(pulse));
	edpc_line_model line_i (.clk_in(clk), .energy_out(energy), .ev_out(ev));
	task automatic chk(input string what, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic st(input logic e);
		chk("power state", {15'h0, e}, {15'h0, state});
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge clk);
		addr <= edpc_pkg::REG_ADDR;
		wen <= 1'h1;
		wd <= d;
		@(posedge clk);
		wen <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		ren <= 1'h1;
		@(posedge clk);
		ren <= 1'h0;
		#1 chk("register", e, rdata);
	endtask
	task automatic t_regs();
		rd(5'h1D, 16'h6011);
		rd(5'h1C, 16'h0000);
		wr(16'h08A5);
		rd(5'h1D, 16'h08A5);
		wr(16'h6011);
		line_i.kick(3'h1);
		st(1'h0);
		rd(5'h1D, 16'h6011);
	endtask
	task automatic t_auto();
		wr(16'hE012);
		line_i.kick(3'h2);
		st(1'h0);
		line_i.kick(3'h1);
		st(1'h0);
		repeat (200) @(posedge clk);
		line_i.kick(3'h1);
		st(1'h1);
		chk("up starts", 16'h0001, 16'(nu));
		wr(16'hE0FF);
		rd(5'h1D, 16'hE7FF);
		rd(5'h1D, 16'hE4FF);
	endtask
	task automatic t_manual();
		wr(16'hD0FF);
		repeat (3) @(posedge clk);
		st(1'h0);
		chk("down starts", 16'h0001, 16'(nd));
		rd(5'h1D, 16'hC0FF);
		wr(16'hD0FF);
		repeat (3) @(posedge clk);
		st(1'h1);
		chk("up starts", 16'h0002, 16'(nu));
	endtask
	task automatic t_down();
		wr(16'hE0FF);
		line_i.energy(1'h0);
		for (int i = 0; i < 20 && state !== 1'h0; i++)
			@(posedge clk);
		st(1'h0);
		line_i.energy(1'h1);
		chk("down starts", 16'h0002, 16'(nd));
	endtask
	task automatic t_burst(input logic [15:0] d, input int n);
		wr(d);
		np = 0;
		line_i.kick(3'h4);
		repeat (8) @(posedge clk);
		chk("pulses", 16'(n), 16'(np));
	endtask
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(5'h1D, 16'h6011);
		st(1'h0);
	endtask
	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_auto();
		t_manual();
		t_down();
		t_burst(16'hE8FF, 1);
		t_burst(16'hE0FF, 4);
		t_reset();
		summarize();
	end
endmodule
